// ==== verilog/acfu_pkg.sv ====
// Shared constants and types for the alignment check fault unit
package acfu_pkg;

  // Exception vectors and codes
  localparam logic [7:0] MISALIGN_VECTOR = 8'h11;
  localparam logic [7:0] PROT_VECTOR = 8'h0d;
  localparam logic [31:0] MISALIGN_ERR_CODE = 32'h0000_0000;
  localparam logic [31:0] PROT_ERR_CODE = 32'h0000_0000;

  // Privilege levels
  localparam logic [1:0] USER_PL = 2'h3;

  // Low address bits that the checks look at
  localparam int ADDR_LO_W = 4;

  // Alignment masks: address bits that must be zero
  localparam logic [3:0] MASK_NONE = 4'h0;
  localparam logic [3:0] MASK_WORD = 4'h1;
  localparam logic [3:0] MASK_DWORD = 4'h3;
  localparam logic [3:0] MASK_QWORD = 4'h7;
  localparam logic [3:0] MASK_DQWORD = 4'hf;

  typedef enum logic [4:0] {
    DT_BYTE, DT_WORD, DT_DWORD, DT_SINGLE, DT_DOUBLE, DT_EXT80,
    DT_QWORD, DT_DQWORD, DT_SELECTOR, DT_FAR32, DT_FAR48, DT_PTR32,
    DT_TABLE_REG, DT_ENV_AREA, DT_SAVE_AREA, DT_BIT_STRING, DT_XSTATE_AREA
  } acfu_dtype_t;

  typedef enum logic [1:0] {
    ACC_DATA, ACC_STACK, ACC_FETCH, ACC_SYSSEG
  } acfu_kind_t;

  typedef enum logic [1:0] {
    IC_PLAIN, IC_UNALIGNED_MOVE, IC_XSTATE, IC_FP_STATE
  } acfu_iclass_t;

  typedef struct packed {
    acfu_dtype_t dtype;
    logic opsz32;
    acfu_kind_t kind;
    acfu_iclass_t iclass;
    logic implicit_pl0;
    logic [15:0] cs;
    logic [31:0] ip;
  } acfu_req_t;

  typedef struct packed {
    logic [7:0] vector;
    logic is_fault;
    logic err_push;
    logic [31:0] err_code;
    logic [15:0] cs;
    logic [31:0] ip;
  } acfu_rpt_t;

endpackage

// ==== verilog/acfu_align_decode.sv ====
// Required alignment decode per operand data type
`timescale 1ns/1ps
`default_nettype none
module acfu_align_decode (
  input wire acfu_pkg::acfu_dtype_t dtype_i,
  input wire logic opsz32_i,
  input wire acfu_pkg::acfu_iclass_t iclass_i,
  output logic [3:0] mask_o,
  output logic ac_type_o,
  output logic wide16_o
);

  always_comb begin
    mask_o = acfu_pkg::MASK_NONE;
    wide16_o = 1'b0;
    case (dtype_i)
      acfu_pkg::DT_WORD,
      acfu_pkg::DT_SELECTOR,
      acfu_pkg::DT_FAR32: mask_o = acfu_pkg::MASK_WORD;
      acfu_pkg::DT_DWORD,
      acfu_pkg::DT_SINGLE,
      acfu_pkg::DT_FAR48,
      acfu_pkg::DT_PTR32: mask_o = acfu_pkg::MASK_DWORD;
      acfu_pkg::DT_TABLE_REG: mask_o = acfu_pkg::MASK_DWORD;
      acfu_pkg::DT_DOUBLE,
      acfu_pkg::DT_EXT80,
      acfu_pkg::DT_QWORD: mask_o = acfu_pkg::MASK_QWORD;
      acfu_pkg::DT_ENV_AREA,
      acfu_pkg::DT_SAVE_AREA: begin
        mask_o = opsz32_i ? acfu_pkg::MASK_DWORD : acfu_pkg::MASK_WORD;
      end
      acfu_pkg::DT_BIT_STRING: begin
        mask_o = opsz32_i ? acfu_pkg::MASK_DWORD : acfu_pkg::MASK_WORD;
      end
      acfu_pkg::DT_DQWORD: begin
        // Unaligned moves relax to quadword checking only
        if (iclass_i == acfu_pkg::IC_UNALIGNED_MOVE) begin
          mask_o = acfu_pkg::MASK_QWORD;
        end else begin
          mask_o = acfu_pkg::MASK_DQWORD;
          wide16_o = 1'b1;
        end
      end
      acfu_pkg::DT_XSTATE_AREA: begin
        mask_o = acfu_pkg::MASK_DQWORD;
        wide16_o = 1'b1;
      end
      default: mask_o = acfu_pkg::MASK_NONE;
    endcase
  end

  // Only word, dword and qword boundaries are eligible
  assign ac_type_o = (mask_o == acfu_pkg::MASK_WORD) ||
                     (mask_o == acfu_pkg::MASK_DWORD) ||
                     (mask_o == acfu_pkg::MASK_QWORD);

endmodule
`default_nettype wire

// ==== verilog/acfu_top.sv ====
// Alignment check fault unit: detects misaligned data operands
//
// Function
// - Misaligned operand fault reported as vector 17, class fault.
// - Only data and stack accesses checked; never fetches or system segments.
// - Word at odd address or dword not multiple of 4 is misaligned.
// - Divisors: 8 quad/double/ext, 16 dquad, 4 single/ptr32/far48, 2 sel/far32.
// - Table register stores checked for 4-byte alignment.
// - FP environment and save areas need 4 or 2 by operand size.
// - Bit strings need 2 or 4 by operand-size attribute.
// - Alignment fault only for word, dword or qword boundary types and extended state areas.
// - Misaligned 128-bit operand gives protection fault, except unaligned moves.
// - Checking needs mask bit, flag bit and privilege level 3.
// - Implicit level-0 references never raise the alignment fault.
// - Extended state area needs 16 bytes; alignment or protection fault by choice.
// - Unaligned 128-bit moves never protection fault; may alignment fault off 8.
// - FP full-state save and restore references are checked.
// - Saved code segment and pointer name the faulting instruction.
// - Faulting instruction does not commit; program restartable there.
`timescale 1ns/1ps
`default_nettype none
module acfu_top #(
  parameter int ADDR_W = 32,
  parameter bit XSTATE_RAISES_MISALIGN = 1'b1,
  parameter bit UMOVE_RAISES_MISALIGN = 1'b1
) (
  input wire logic CLK_I,
  input wire logic NRST_I,
  input wire logic REQ_VALID_I,
  input wire acfu_pkg::acfu_req_t REQ_I,
  input wire logic [ADDR_W-1:0] ADDR_I,
  input wire logic ALIGN_MASK_BIT_I,
  input wire logic ALIGN_CHECK_FLAG_I,
  input wire logic [1:0] CURRENT_PRIVILEGE_LEVEL_I,
  input wire logic DELIV_ACK_I,
  output logic REQ_READY_O,
  output logic SUPPRESS_O,
  output logic MISALIGN_FAULT_O,
  output logic GENERAL_PROTECTION_FAULT_O,
  output var acfu_pkg::acfu_rpt_t REPORT_O
);

  initial begin
    if (ADDR_W < acfu_pkg::ADDR_LO_W) begin
      $error("ADDR_W too small for alignment checks");
    end
  end

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_MISALIGN,
    ST_PROT
  } acfu_state_t;

  acfu_state_t state_reg;
  acfu_state_t state_next;
  acfu_pkg::acfu_rpt_t rpt_reg;
  acfu_pkg::acfu_rpt_t rpt_next;

  logic take;
  logic check_en;
  logic data_acc;
  logic [3:0] addr_lo;
  logic [3:0] req_mask;
  logic ac_type;
  logic wide16;
  logic mis;
  logic ac_hit;
  logic gp_hit;

  function automatic logic misaligned(input logic [3:0] a, input logic [3:0] m);
    return |(a & m);
  endfunction

  acfu_align_decode u_decode (
    .dtype_i(REQ_I.dtype),
    .opsz32_i(REQ_I.opsz32),
    .iclass_i(REQ_I.iclass),
    .mask_o(req_mask),
    .ac_type_o(ac_type),
    .wide16_o(wide16)
  );

  assign addr_lo = ADDR_I[acfu_pkg::ADDR_LO_W-1:0];
  assign take = REQ_VALID_I && REQ_READY_O;

  assign check_en = ALIGN_MASK_BIT_I && ALIGN_CHECK_FLAG_I &&
                    (CURRENT_PRIVILEGE_LEVEL_I == acfu_pkg::USER_PL);

  assign data_acc = (REQ_I.kind == acfu_pkg::ACC_DATA) ||
                    (REQ_I.kind == acfu_pkg::ACC_STACK);

  assign mis = misaligned(addr_lo, req_mask);

  // Fault decision; the two are exclusive by construction
  always_comb begin
    ac_hit = 1'b0;
    gp_hit = 1'b0;
    if (take && data_acc && mis) begin
      if (wide16) begin
        // Extended state area may take the alignment fault when checking is on
        if (REQ_I.dtype == acfu_pkg::DT_XSTATE_AREA && check_en &&
            XSTATE_RAISES_MISALIGN && !REQ_I.implicit_pl0) begin
          ac_hit = 1'b1;
        end else begin
          gp_hit = 1'b1;
        end
      end else if (check_en && ac_type && !REQ_I.implicit_pl0) begin
        if (REQ_I.iclass == acfu_pkg::IC_UNALIGNED_MOVE) begin
          ac_hit = UMOVE_RAISES_MISALIGN;
        end else begin
          ac_hit = 1'b1;
        end
      end
    end
  end

  // Pipeline must drop the access in the same cycle
  assign SUPPRESS_O = ac_hit || gp_hit;

  // Only one fault outstanding; core stalls until delivery takes it
  assign REQ_READY_O = (state_reg == ST_IDLE);
  assign MISALIGN_FAULT_O = (state_reg == ST_MISALIGN);
  assign GENERAL_PROTECTION_FAULT_O = (state_reg == ST_PROT);
  assign REPORT_O = rpt_reg;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (ac_hit) begin
          state_next = ST_MISALIGN;
        end else if (gp_hit) begin
          state_next = ST_PROT;
        end
      end
      ST_MISALIGN,
      ST_PROT: begin
        if (DELIV_ACK_I) begin
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_comb begin
    rpt_next = rpt_reg;
    if (ac_hit) begin
      rpt_next.vector = acfu_pkg::MISALIGN_VECTOR;
      rpt_next.is_fault = 1'b1;
      rpt_next.err_push = 1'b1;
      rpt_next.err_code = acfu_pkg::MISALIGN_ERR_CODE;
      rpt_next.cs = REQ_I.cs;
      rpt_next.ip = REQ_I.ip;
    end else if (gp_hit) begin
      rpt_next.vector = acfu_pkg::PROT_VECTOR;
      rpt_next.is_fault = 1'b1;
      rpt_next.err_push = 1'b1;
      rpt_next.err_code = acfu_pkg::PROT_ERR_CODE;
      rpt_next.cs = REQ_I.cs;
      rpt_next.ip = REQ_I.ip;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      rpt_reg <= '0;
    end else begin
      rpt_reg <= rpt_next;
    end
  end

  // Checks

  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!NRST_I);

  sequence s_ac_taken;
    take && ac_hit;
  endsequence

  sequence s_ac_reported;
    MISALIGN_FAULT_O && REPORT_O.vector == acfu_pkg::MISALIGN_VECTOR;
  endsequence

  property p_vector;
    MISALIGN_FAULT_O |-> REPORT_O.vector == acfu_pkg::MISALIGN_VECTOR && REPORT_O.is_fault;
  endproperty
  a_vector: assert property (p_vector) else $error("bad vector");

  property p_no_fetch;
    take && !data_acc |=> !MISALIGN_FAULT_O && !GENERAL_PROTECTION_FAULT_O;
  endproperty
  a_no_fetch: assert property (p_no_fetch) else $error("fetch checked");

  property p_word_odd;
    take && check_en && data_acc && !REQ_I.implicit_pl0 &&
      REQ_I.dtype == acfu_pkg::DT_WORD && addr_lo[0] |=> s_ac_reported;
  endproperty
  a_word_odd: assert property (p_word_odd) else $error("odd word missed");

  property p_qword;
    take && check_en && data_acc && !REQ_I.implicit_pl0 &&
      REQ_I.dtype == acfu_pkg::DT_QWORD && addr_lo[2:0] != 3'h0 |=> MISALIGN_FAULT_O;
  endproperty
  a_qword: assert property (p_qword) else $error("qword missed");

  property p_table;
    take && check_en && data_acc && !REQ_I.implicit_pl0 &&
      REQ_I.dtype == acfu_pkg::DT_TABLE_REG && addr_lo[1:0] != 2'h0 |=> MISALIGN_FAULT_O;
  endproperty
  a_table: assert property (p_table) else $error("table store missed");

  property p_env16;
    take && data_acc && REQ_I.dtype == acfu_pkg::DT_ENV_AREA &&
      !REQ_I.opsz32 && addr_lo[1] && !addr_lo[0] |=> !MISALIGN_FAULT_O;
  endproperty
  a_env16: assert property (p_env16) else $error("env area overchecked");

  property p_bitstr;
    take && check_en && data_acc && !REQ_I.implicit_pl0 &&
      REQ_I.dtype == acfu_pkg::DT_BIT_STRING && REQ_I.opsz32 &&
      addr_lo[1] |=> MISALIGN_FAULT_O;
  endproperty
  a_bitstr: assert property (p_bitstr) else $error("bit string missed");

  property p_dq_gp;
    take && data_acc && REQ_I.dtype == acfu_pkg::DT_DQWORD &&
      REQ_I.iclass == acfu_pkg::IC_PLAIN && addr_lo != 4'h0 |=>
      GENERAL_PROTECTION_FAULT_O && !MISALIGN_FAULT_O;
  endproperty
  a_dq_gp: assert property (p_dq_gp) else $error("dquad not protection");

  property p_gate;
    $rose(MISALIGN_FAULT_O) |-> $past(check_en) || $past(REQ_I.dtype) ==
      acfu_pkg::DT_XSTATE_AREA && $past(check_en);
  endproperty
  a_gate: assert property (p_gate) else $error("fault while disabled");

  property p_pl0;
    take && REQ_I.implicit_pl0 |=> !MISALIGN_FAULT_O;
  endproperty
  a_pl0: assert property (p_pl0) else $error("implicit ref faulted");

  property p_xstate;
    take && data_acc && REQ_I.dtype == acfu_pkg::DT_XSTATE_AREA &&
      addr_lo != 4'h0 |=> MISALIGN_FAULT_O != GENERAL_PROTECTION_FAULT_O;
  endproperty
  a_xstate: assert property (p_xstate) else $error("xstate not faulted");

  property p_umove;
    take && REQ_I.iclass == acfu_pkg::IC_UNALIGNED_MOVE |=> !GENERAL_PROTECTION_FAULT_O;
  endproperty
  a_umove: assert property (p_umove) else $error("unaligned move protection");

  property p_fpsave;
    take && check_en && data_acc && !REQ_I.implicit_pl0 &&
      REQ_I.dtype == acfu_pkg::DT_SAVE_AREA && addr_lo[0] |=> MISALIGN_FAULT_O;
  endproperty
  a_fpsave: assert property (p_fpsave) else $error("fp save missed");

  property p_saved_ip;
    logic [31:0] ip_v;
    (s_ac_taken, ip_v = REQ_I.ip) |=> s_ac_reported ##0 REPORT_O.ip == ip_v;
  endproperty
  a_saved_ip: assert property (p_saved_ip) else $error("wrong saved pointer");

  property p_suppress;
    $rose(MISALIGN_FAULT_O) |-> $past(SUPPRESS_O) && !REQ_READY_O;
  endproperty
  a_suppress: assert property (p_suppress) else $error("faulting access committed");

  property p_hold;
    MISALIGN_FAULT_O && !DELIV_ACK_I |=> MISALIGN_FAULT_O && $stable(REPORT_O);
  endproperty
  a_hold: assert property (p_hold) else $error("report dropped");

  property p_err;
    MISALIGN_FAULT_O |-> REPORT_O.err_push && REPORT_O.err_code == acfu_pkg::MISALIGN_ERR_CODE;
  endproperty
  a_err: assert property (p_err) else $error("error code wrong");

  property p_gp_vector;
    GENERAL_PROTECTION_FAULT_O |-> REPORT_O.vector == acfu_pkg::PROT_VECTOR;
  endproperty
  a_gp_vector: assert property (p_gp_vector) else $error("bad protection vector");

  property p_gp_hold;
    GENERAL_PROTECTION_FAULT_O && !DELIV_ACK_I |=>
      GENERAL_PROTECTION_FAULT_O && $stable(REPORT_O);
  endproperty
  a_gp_hold: assert property (p_gp_hold) else $error("protection report dropped");

  property p_release;
    (MISALIGN_FAULT_O || GENERAL_PROTECTION_FAULT_O) && DELIV_ACK_I |=>
      REQ_READY_O && !MISALIGN_FAULT_O && !GENERAL_PROTECTION_FAULT_O;
  endproperty
  a_release: assert property (p_release) else $error("fault not released");

  property p_refuse;
    !REQ_READY_O |-> !SUPPRESS_O;
  endproperty
  a_refuse: assert property (p_refuse) else $error("refused access suppressed");

  property p_byte;
    take && REQ_I.dtype == acfu_pkg::DT_BYTE |=> !MISALIGN_FAULT_O;
  endproperty
  a_byte: assert property (p_byte) else $error("byte faulted");

  property p_exclusive;
    !(MISALIGN_FAULT_O && GENERAL_PROTECTION_FAULT_O);
  endproperty
  a_exclusive: assert property (p_exclusive) else $error("two faults at once");

endmodule
`default_nettype wire

// ==== tb/acfu_core_model.sv ====
// Exception delivery side model: acknowledges a pending fault after a delay
`timescale 1ns/1ps
`default_nettype none
module acfu_core_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic fault_i,
  input wire logic [3:0] delay_i,
  output logic ack_o
);
  logic [3:0] wait_reg;
  initial ack_o = 1'h0;
  initial wait_reg = 4'h0;
  // Falling edge, so the unit samples a settled level
  always @(negedge clk_i) begin
    if (!rst_n_i) begin
      wait_reg <= 4'h0;
      ack_o <= 1'h0;
    end else if (fault_i && !ack_o && wait_reg >= delay_i) begin
      ack_o <= 1'h1;
      wait_reg <= 4'h0;
    end else begin
      // One-cycle pulse; a held level would ack the next fault too
      ack_o <= 1'h0;
      if (fault_i && !ack_o) begin
        wait_reg <= wait_reg + 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
// Self-checking bench for the alignment check fault unit
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 1'h1;
  logic rst_n = 1'h0;
  logic valid = 1'h0;
  acfu_pkg::acfu_req_t req = '0;
  logic [31:0] addr = 32'h0000_0000;
  logic am = 1'h1;
  logic acf = 1'h1;
  logic [1:0] current_privilege_level = 2'h3;
  logic [3:0] dly = 4'h1;
  logic [15:0] seq = 16'h0000;
  logic ack;
  logic ready;
  logic supp;
  logic acf_o;
  logic gpf_o;
  acfu_pkg::acfu_rpt_t rpt;
  int errors = 0;
  int n_compared = 0;

  always #25 clk = ~clk;

  acfu_top #(.ADDR_W(32), .XSTATE_RAISES_MISALIGN(1'h1), .UMOVE_RAISES_MISALIGN(1'h1)) DUT (
    .CLK_I(clk), .NRST_I(rst_n), .REQ_VALID_I(valid), .REQ_I(req), .ADDR_I(addr),
    .ALIGN_MASK_BIT_I(am), .ALIGN_CHECK_FLAG_I(acf), .CURRENT_PRIVILEGE_LEVEL_I(current_privilege_level),
    .DELIV_ACK_I(ack), .REQ_READY_O(ready), .SUPPRESS_O(supp), .MISALIGN_FAULT_O(acf_o),
    .GENERAL_PROTECTION_FAULT_O(gpf_o), .REPORT_O(rpt));

  acfu_core_model MODEL (.clk_i(clk), .rst_n_i(rst_n), .fault_i(acf_o | gpf_o),
    .delay_i(dly), .ack_o(ack));

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic print_verdict;
    $display("Counts: %0d compared, %0d errors", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  function automatic int div_of(input acfu_pkg::acfu_dtype_t d, input logic o);
    case (d)
      acfu_pkg::DT_WORD, acfu_pkg::DT_SELECTOR, acfu_pkg::DT_FAR32: return 2;
      acfu_pkg::DT_DWORD, acfu_pkg::DT_SINGLE, acfu_pkg::DT_FAR48, acfu_pkg::DT_PTR32,
      acfu_pkg::DT_TABLE_REG: return 4;
      acfu_pkg::DT_DOUBLE, acfu_pkg::DT_EXT80, acfu_pkg::DT_QWORD: return 8;
      acfu_pkg::DT_DQWORD, acfu_pkg::DT_XSTATE_AREA: return 16;
      acfu_pkg::DT_ENV_AREA, acfu_pkg::DT_SAVE_AREA, acfu_pkg::DT_BIT_STRING: return o ? 4 : 2;
      default: return 1;
    endcase
  endfunction

  task automatic drive(input acfu_pkg::acfu_dtype_t d, input logic [31:0] a, input logic o,
    input acfu_pkg::acfu_kind_t k, input acfu_pkg::acfu_iclass_t ic, input logic im);
    seq++;
    req = '{dtype: d, opsz32: o, kind: k, iclass: ic, implicit_pl0: im,
      cs: 16'h0100 + seq, ip: {16'h4000, seq}};
    addr = a;
    valid = 1'h1;
  endtask

  task automatic wait_idle;
    int n;
    n = 0;
    while ((acf_o | gpf_o) && n < 40) begin
      @(negedge clk);
      n++;
    end
    chk(ready, 1'h1);
  endtask

  task automatic acc(input acfu_pkg::acfu_dtype_t d, input logic [31:0] a, input logic eac,
    input logic egp, input logic o = 1'h1, input acfu_pkg::acfu_kind_t k = acfu_pkg::ACC_DATA,
    input acfu_pkg::acfu_iclass_t ic = acfu_pkg::IC_PLAIN, input logic im = 1'h0);
    logic [47:0] loc;
    @(negedge clk);
    drive(d, a, o, k, ic, im);
    loc = {req.cs, req.ip};
    #1;
    chk(ready, 1'h1);
    chk(supp, eac | egp);
    @(negedge clk);
    valid = 1'h0;
    chk({acf_o, gpf_o}, {eac, egp});
    if (eac) chk({rpt.vector, rpt.is_fault, rpt.err_push, rpt.err_code}, {8'h11, 34'h3_0000_0000});
    if (egp) chk(rpt.vector, 8'h0d);
    if (eac | egp) chk({rpt.cs, rpt.ip}, loc);
    wait_idle;
  endtask

  task automatic t_dtypes;
    acfu_pkg::acfu_dtype_t d;
    int v;
    for (int i = 0; i <= 16; i++) begin
      for (int o = 0; o < 2; o++) begin
        d = acfu_pkg::acfu_dtype_t'(i);
        v = div_of(d, o[0]);
        // Offset of half the divisor, then an aligned one with high bits set
        acc(d, 32'h0010_0000 + (v + 1) / 2, v inside {2, 4, 8} || d == acfu_pkg::DT_XSTATE_AREA,
          d == acfu_pkg::DT_DQWORD, o[0]);
        acc(d, 32'h0abc_0000 + v * 3, 1'h0, 1'h0, o[0]);
      end
    end
    $display("t_dtypes done");
  endtask

  task automatic t_enable;
    for (int m = 0; m < 16; m++) begin
      am = m[3];
      acf = m[2];
      current_privilege_level = m[1:0];
      acc(acfu_pkg::DT_DWORD, 32'h0000_0002, m == 15, 1'h0);
    end
    $display("t_enable done");
  endtask

  task automatic t_kinds;
    acc(acfu_pkg::DT_WORD, 32'h0000_0001, 1'h1, 1'h0, 1'h1, acfu_pkg::ACC_STACK);
    acc(acfu_pkg::DT_WORD, 32'h0000_0001, 1'h0, 1'h0, 1'h1, acfu_pkg::ACC_FETCH);
    acc(acfu_pkg::DT_WORD, 32'h0000_0001, 1'h0, 1'h0, 1'h1, acfu_pkg::ACC_SYSSEG);
    acc(acfu_pkg::DT_WORD, 32'h0000_0001, 1'h0, 1'h0, 1'h1, acfu_pkg::ACC_DATA,
      acfu_pkg::IC_PLAIN, 1'h1);
    acc(acfu_pkg::DT_TABLE_REG, 32'h0000_0002, 1'h1, 1'h0);
    acc(acfu_pkg::DT_SAVE_AREA, 32'h0000_0002, 1'h1, 1'h0, 1'h1, acfu_pkg::ACC_DATA,
      acfu_pkg::IC_FP_STATE);
    $display("t_kinds done");
  endtask

  task automatic t_gp;
    current_privilege_level = 2'h0;
    acc(acfu_pkg::DT_DQWORD, 32'h0000_0004, 1'h0, 1'h1);
    acc(acfu_pkg::DT_XSTATE_AREA, 32'h0000_0008, 1'h0, 1'h1);
    acc(acfu_pkg::DT_DQWORD, 32'h0000_0004, 1'h0, 1'h0, 1'h1, acfu_pkg::ACC_DATA,
      acfu_pkg::IC_UNALIGNED_MOVE);
    current_privilege_level = 2'h3;
    acc(acfu_pkg::DT_DQWORD, 32'h0000_0004, 1'h1, 1'h0, 1'h1, acfu_pkg::ACC_DATA,
      acfu_pkg::IC_UNALIGNED_MOVE);
    acc(acfu_pkg::DT_DQWORD, 32'h0000_0008, 1'h0, 1'h0, 1'h1, acfu_pkg::ACC_DATA,
      acfu_pkg::IC_UNALIGNED_MOVE);
    $display("t_gp done");
  endtask

  task automatic t_busy;
    logic [47:0] loc;
    dly = 4'h4;
    @(negedge clk);
    drive(acfu_pkg::DT_WORD, 32'h0000_0000, 1'h1, acfu_pkg::ACC_DATA, acfu_pkg::IC_PLAIN, 1'h0);
    #1;
    chk(supp, 1'h0);
    @(negedge clk);
    drive(acfu_pkg::DT_WORD, 32'h0000_0003, 1'h1, acfu_pkg::ACC_DATA, acfu_pkg::IC_PLAIN, 1'h0);
    loc = {req.cs, req.ip};
    #1;
    chk(supp, 1'h1);
    @(negedge clk);
    // Pending fault: this request must be refused untouched
    drive(acfu_pkg::DT_DWORD, 32'h0000_0001, 1'h1, acfu_pkg::ACC_DATA, acfu_pkg::IC_PLAIN, 1'h0);
    #1;
    chk({ready, supp, acf_o}, 3'h1);
    @(negedge clk);
    valid = 1'h0;
    chk({rpt.cs, rpt.ip}, loc);
    wait_idle;
    @(negedge clk);
    chk({acf_o, gpf_o}, 2'h0);
    dly = 4'h1;
    $display("t_busy done");
  endtask

  initial begin
    repeat (4) @(negedge clk);
    chk({ready, acf_o, gpf_o}, 3'h4);
    chk({rpt.vector, rpt.is_fault, rpt.err_push, rpt.err_code}, 64'h0000_0000_0000_0000);
    chk({rpt.cs, rpt.ip}, 64'h0000_0000_0000_0000);
    rst_n = 1'h1;
    t_dtypes();
    t_enable();
    t_kinds();
    t_gp();
    t_busy();
    print_verdict();
  end

  initial begin
    #(50 * 4000);
    errors++;
    print_verdict();
  end
endmodule
`default_nettype wire
